// [rtl/lt_error_detect.sv]
// APB register pair for logical/transport error reporting
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

module lt_error_detect (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        load_store_unit_error_resp,
    input  wire logic        message_transmit_unit_error_resp,
    input  wire logic        message_receive_unit_bad_format,
    input  wire logic        load_store_unit_illegal_fields,
    input  wire logic        message_transmit_unit_illegal_fields,
    input  wire logic        memory_access_unit_illegal_fields,
    input  wire logic        message_receive_unit_illegal_fields,
    input  wire logic        message_receive_unit_req_timeout,
    input  wire logic        load_store_unit_resp_timeout,
    input  wire logic        message_transmit_unit_resp_timeout,
    input  wire logic        load_store_unit_unexpected_resp,
    input  wire logic        message_transmit_unit_unexpected_resp,
    input  wire logic        memory_access_unit_unsupported,
    input  wire logic        message_receive_unit_queue_block,
    input  wire logic        memory_access_unit_dma_blocked,
    output logic      [31:0] error_detect
);
    import lt_err_pkg::*;

    // ********************************
    // Decode
    // ********************************
    function automatic logic [31:0] byte_mask(input logic [3:0] s);
        byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : byte_mask

    logic        setup;
    logic        access;
    logic        hit_header;
    logic        hit_detect;
    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic [31:0] flags;
    logic [31:0] next_prdata;

    // Answer in the first access cycle, so no wait states
    assign setup      = psel && !penable;
    assign access     = psel && penable;
    assign hit_header = (paddr == ADDR_BLOCK_HEADER);
    assign hit_detect = (paddr == ADDR_ERROR_DETECT);

    // ********************************
    // Event collection
    // ********************************
    always_comb begin
        set_vec = 32'h00000000;
        set_vec[BIT_IO_ERR_RESP]     = load_store_unit_error_resp;
        set_vec[BIT_MSG_ERR_RESP]    = message_transmit_unit_error_resp;
        set_vec[BIT_BAD_MSG_FORMAT]  = message_receive_unit_bad_format;
        set_vec[BIT_ILLEGAL_FIELDS]  = load_store_unit_illegal_fields
            | message_transmit_unit_illegal_fields
            | memory_access_unit_illegal_fields
            | message_receive_unit_illegal_fields;
        set_vec[BIT_MESSAGE_REQUEST_TIMEOUT_FLAG] = message_receive_unit_req_timeout;
        set_vec[BIT_RESP_TIMEOUT]    = load_store_unit_resp_timeout
            | message_transmit_unit_resp_timeout;
        set_vec[BIT_UNEXPECTED_RESP] = load_store_unit_unexpected_resp
            | message_transmit_unit_unexpected_resp;
        set_vec[BIT_UNSUPPORTED]     = memory_access_unit_unsupported;
        set_vec[BIT_RX_QUEUE_BLOCK]  = message_receive_unit_queue_block;
        set_vec[BIT_DMA_BLOCK]       = memory_access_unit_dma_blocked;
    end

    // Only written zeros in enabled lanes clear; ones do nothing
    always_comb begin
        clear_vec = 32'h00000000;
        if (setup && pwrite && hit_detect) begin
            clear_vec = ~pwdata & byte_mask(pstrb) & DETECT_MASK;
        end
    end

    lt_err_sticky u_sticky (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_vec   (set_vec),
        .clear_vec (clear_vec),
        .flags     (flags)
    );

    // ********************************
    // Read path
    // ********************************
    always_comb begin
        next_prdata = 32'h00000000;
        if (hit_header) begin
            next_prdata = {NEXT_BLOCK_POINTER, FEATURE_IDENTIFIER};
        end else if (hit_detect) begin
            next_prdata = flags & DETECT_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !(hit_header || hit_detect);
            prdata  <= (setup && !pwrite) ? next_prdata : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_detect <= DETECT_RESET;
        end else begin
            error_detect <= flags;
        end
    end

    // ********************************
    // Checks
    // ********************************
    property p_header_ro;
        @(posedge pclk) disable iff (!presetn)
        (access && pready && !pwrite && hit_header)
            |-> prdata == {NEXT_BLOCK_POINTER, FEATURE_IDENTIFIER};
    endproperty
    a_header_ro: assert property (p_header_ro)
        else $error("header read value wrong");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (flags & ~DETECT_MASK) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved detect bit set");

    property p_io_set;
        @(posedge pclk) disable iff (!presetn)
        load_store_unit_error_resp |=> flags[BIT_IO_ERR_RESP];
    endproperty
    a_io_set: assert property (p_io_set)
        else $error("io error response not recorded");

    property p_illegal_set;
        @(posedge pclk) disable iff (!presetn)
        (memory_access_unit_illegal_fields
         || message_transmit_unit_illegal_fields)
            |=> flags[BIT_ILLEGAL_FIELDS];
    endproperty
    a_illegal_set: assert property (p_illegal_set)
        else $error("illegal fields not recorded");

    property p_timeout_set;
        @(posedge pclk) disable iff (!presetn)
        (load_store_unit_resp_timeout || message_transmit_unit_resp_timeout)
            |=> flags[BIT_RESP_TIMEOUT];
    endproperty
    a_timeout_set: assert property (p_timeout_set)
        else $error("response timeout not recorded");

    property p_dma_set;
        @(posedge pclk) disable iff (!presetn)
        memory_access_unit_dma_blocked ##1 !(setup && pwrite && hit_detect)
            |=> flags[BIT_DMA_BLOCK];
    endproperty
    a_dma_set: assert property (p_dma_set)
        else $error("dma block flag lost");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        (flags[BIT_UNSUPPORTED] && !(setup && pwrite && hit_detect))
            |=> flags[BIT_UNSUPPORTED];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a clear");

    property p_clear_zero;
        @(posedge pclk) disable iff (!presetn)
        (setup && pwrite && hit_detect && pstrb[3]
         && !pwdata[BIT_IO_ERR_RESP] && !load_store_unit_error_resp)
            |=> !flags[BIT_IO_ERR_RESP];
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("write zero did not clear");

    property p_write_one;
        @(posedge pclk) disable iff (!presetn)
        (setup && pwrite && hit_detect && pwdata[BIT_RX_QUEUE_BLOCK]
         && !message_receive_unit_queue_block)
            |=> flags[BIT_RX_QUEUE_BLOCK] == $past(flags[BIT_RX_QUEUE_BLOCK]);
    endproperty
    a_write_one: assert property (p_write_one)
        else $error("write one changed a flag");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (setup && pwrite && hit_detect && message_receive_unit_queue_block)
            |=> flags[BIT_RX_QUEUE_BLOCK];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("set lost to clear");

    property p_ready_one;
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("pready not a single cycle");

    // ********************************
    // Event and transfer checks
    // ********************************
    property p_msg_resp_set;
        @(posedge pclk) disable iff (!presetn)
        message_transmit_unit_error_resp |=> flags[BIT_MSG_ERR_RESP];
    endproperty
    a_msg_resp_set: assert property (p_msg_resp_set)
        else $error("message error response not recorded");

    property p_format_set;
        @(posedge pclk) disable iff (!presetn)
        message_receive_unit_bad_format |=> flags[BIT_BAD_MSG_FORMAT];
    endproperty
    a_format_set: assert property (p_format_set)
        else $error("bad message format not recorded");

    property p_req_illegal_set;
        @(posedge pclk) disable iff (!presetn)
        (load_store_unit_illegal_fields || message_receive_unit_illegal_fields)
            |=> flags[BIT_ILLEGAL_FIELDS];
    endproperty
    a_req_illegal_set: assert property (p_req_illegal_set)
        else $error("illegal fields not recorded");

    property p_req_timeout_set;
        @(posedge pclk) disable iff (!presetn)
        message_receive_unit_req_timeout |=> flags[BIT_MESSAGE_REQUEST_TIMEOUT_FLAG];
    endproperty
    a_req_timeout_set: assert property (p_req_timeout_set)
        else $error("message request timeout not recorded");

    property p_unexpected_set;
        @(posedge pclk) disable iff (!presetn)
        (load_store_unit_unexpected_resp
         || message_transmit_unit_unexpected_resp)
            |=> flags[BIT_UNEXPECTED_RESP];
    endproperty
    a_unexpected_set: assert property (p_unexpected_set)
        else $error("unexpected response not recorded");

    property p_unsupported_set;
        @(posedge pclk) disable iff (!presetn)
        memory_access_unit_unsupported |=> flags[BIT_UNSUPPORTED];
    endproperty
    a_unsupported_set: assert property (p_unsupported_set)
        else $error("unsupported transaction not recorded");

    property p_queue_block_set;
        @(posedge pclk) disable iff (!presetn)
        message_receive_unit_queue_block |=> flags[BIT_RX_QUEUE_BLOCK];
    endproperty
    a_queue_block_set: assert property (p_queue_block_set)
        else $error("receive queue block not recorded");

    // A stray set would hide the first real error from software
    property p_io_quiet;
        @(posedge pclk) disable iff (!presetn)
        (!flags[BIT_IO_ERR_RESP] && !load_store_unit_error_resp)
            |=> !flags[BIT_IO_ERR_RESP];
    endproperty
    a_io_quiet: assert property (p_io_quiet)
        else $error("io error flag rose without an event");

    property p_set_all;
        @(posedge pclk) disable iff (!presetn)
        (set_vec != 32'h00000000)
            |=> (flags & $past(set_vec)) == $past(set_vec);
    endproperty
    a_set_all: assert property (p_set_all)
        else $error("event lost from the detect register");

    property p_detect_read;
        @(posedge pclk) disable iff (!presetn)
        (access && pready && !pwrite && hit_detect)
            |-> (prdata == $past(flags))
                && ((prdata & ~DETECT_MASK) == 32'h00000000);
    endproperty
    a_detect_read: assert property (p_detect_read)
        else $error("detect read value wrong");

    property p_mirror;
        @(posedge pclk) disable iff (!presetn)
        error_detect == $past(flags);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("detect output does not follow the flags");

    property p_write_quiet;
        @(posedge pclk) disable iff (!presetn)
        (access && pready && pwrite) |-> prdata == 32'h00000000;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("read data driven during a write");

    // Unmapped addresses answer with an error and no data
    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        (setup && !(hit_header || hit_detect))
            |=> pready && pslverr && prdata == 32'h00000000;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped address not refused");

    property p_mapped_ok;
        @(posedge pclk) disable iff (!presetn)
        (setup && (hit_header || hit_detect)) |=> pready && !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("error reported for a mapped register");

    c_header_read: cover property (@(posedge pclk) disable iff (!presetn)
        access && pready && !pwrite && hit_header);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_detect && flags != 32'h00000000);
    c_collide: cover property (@(posedge pclk) disable iff (!presetn)
        setup && pwrite && hit_detect && |set_vec);
    c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);

endmodule : lt_error_detect

// [rtl/lt_err_pkg.sv]
// Constants for the logical/transport error register pair
package lt_err_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam logic [15:0] ADDR_BLOCK_HEADER = 16'h2000;
    localparam logic [15:0] ADDR_ERROR_DETECT = 16'h2008;

    // ********************************
    // Block header fields
    // ********************************
    localparam logic [15:0] NEXT_BLOCK_POINTER = 16'h0000;
    localparam logic [15:0] FEATURE_IDENTIFIER = 16'h0007;

    // ********************************
    // Detect bit positions
    // ********************************
    localparam int BIT_IO_ERR_RESP     = 31;
    localparam int BIT_MSG_ERR_RESP    = 30;
    localparam int BIT_BAD_MSG_FORMAT  = 28;
    localparam int BIT_ILLEGAL_FIELDS  = 27;
    localparam int BIT_MESSAGE_REQUEST_TIMEOUT_FLAG = 25;
    localparam int BIT_RESP_TIMEOUT    = 24;
    localparam int BIT_UNEXPECTED_RESP = 23;
    localparam int BIT_UNSUPPORTED     = 22;
    localparam int BIT_RX_QUEUE_BLOCK  = 7;
    localparam int BIT_DMA_BLOCK       = 6;

    localparam logic [31:0] DETECT_MASK  = 32'hdbc000c0;
    localparam logic [31:0] DETECT_RESET = 32'h00000000;

endpackage : lt_err_pkg

// [rtl/lt_err_sticky.sv]
// Sticky flag bank: hardware set wins over software clear
`timescale 1ns/1ps
module lt_err_sticky (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] set_vec,
    input  wire logic [31:0] clear_vec,
    output logic      [31:0] flags
);
    import lt_err_pkg::*;

    // ********************************
    // Flag storage
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= DETECT_RESET;
        end else begin
            // Set after clear, so a same-cycle event survives
            flags <= ((flags & ~clear_vec) | set_vec) & DETECT_MASK;
        end
    end

endmodule : lt_err_sticky

// [bench/lt_event_src.sv]
// Model of the unit error event lines feeding the detect register
`timescale 1ns/1ps
// ********************************
// Event source model
// ********************************
module lt_event_src (
    input  wire logic        pclk,
    output logic      [14:0] events
);
    initial events = 15'h0000;

    // One-cycle pulse; the line returns low, its idle level
    task automatic fire(input int idx);
        @(posedge pclk);
        events[idx] <= 1'b1;
        @(posedge pclk);
        events[idx] <= 1'b0;
    endtask : fire
endmodule : lt_event_src

// [bench/lt_error_detect_tb.sv]
// Self-checking bench for the error register pair
`timescale 1ns/1ps
// ********************************
// Testbench top
// ********************************
module lt_error_detect_tb;
    import lt_err_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [15:0] paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, error_detect, rd, exp_det;
    logic [14:0] ev;
    int          fail_count, tests_run;
    // Detect bit reached by each event line, in port order
    int          bitpos [15] = '{31, 30, 28, 27, 27, 27, 27, 25, 24, 24,
                                 23, 23, 22, 7, 6};

    lt_event_src src (.pclk(pclk), .events(ev));

    lt_error_detect uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .error_detect(error_detect),
        .load_store_unit_error_resp(ev[0]),
        .message_transmit_unit_error_resp(ev[1]),
        .message_receive_unit_bad_format(ev[2]),
        .load_store_unit_illegal_fields(ev[3]),
        .message_transmit_unit_illegal_fields(ev[4]),
        .memory_access_unit_illegal_fields(ev[5]),
        .message_receive_unit_illegal_fields(ev[6]),
        .message_receive_unit_req_timeout(ev[7]),
        .load_store_unit_resp_timeout(ev[8]),
        .message_transmit_unit_resp_timeout(ev[9]),
        .load_store_unit_unexpected_resp(ev[10]),
        .message_transmit_unit_unexpected_resp(ev[11]),
        .memory_access_unit_unsupported(ev[12]),
        .message_receive_unit_queue_block(ev[13]),
        .memory_access_unit_dma_blocked(ev[14]));

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check

    // Setup, access, then wait for pready; never assumes wait states
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= wr ? 4'hf : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        summarize();
    end

    initial begin
        fail_count = 0;
        tests_run  = 0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0000;
        pwdata  = 32'h00000000;
        pstrb   = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
        check(rd, 32'h00000000);
        apb(1'b0, ADDR_BLOCK_HEADER, 32'h00000000);
        check(rd, 32'h00000007);
        apb(1'b1, ADDR_BLOCK_HEADER, 32'hffffffff);
        apb(1'b0, ADDR_BLOCK_HEADER, 32'h00000000);
        check(rd, 32'h00000007);
        exp_det = 32'h00000000;
        for (int i = 0; i < 15; i++) begin
            // Clear only the target bit, so shared bits prove every line
            apb(1'b1, ADDR_ERROR_DETECT, ~(32'h00000001 << bitpos[i]));
            src.fire(i);
            exp_det[bitpos[i]] = 1'b1;
            apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
            check(rd, exp_det);
            check(error_detect, exp_det);
        end
        // Ones and reserved positions must not disturb anything
        apb(1'b1, ADDR_ERROR_DETECT, 32'hffffffff);
        apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
        check(rd, exp_det);
        apb(1'b1, ADDR_ERROR_DETECT, 32'h7fffffff);
        exp_det[31] = 1'b0;
        apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
        check(rd, exp_det);
        apb(1'b1, 16'h2004, 32'h00000000);
        check({31'h0, err}, 32'h00000001);
        apb(1'b0, 16'h2004, 32'h00000000);
        check(rd, 32'h00000000);
        apb(1'b1, ADDR_ERROR_DETECT, 32'h00000000);
        apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
        check(rd, 32'h00000000);
        // Event lands on the very edge that applies the clear
        fork
            src.fire(13);
            apb(1'b1, ADDR_ERROR_DETECT, 32'h00000000);
        join
        apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
        check(rd, 32'h00000080);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_ERROR_DETECT, 32'h00000000);
        check(rd, 32'h00000000);
        check(error_detect, 32'h00000000);
        summarize();
    end
endmodule : lt_error_detect_tb
